// >>> ssp_pkg.sv
// Shared constants and types of the serial shift port.
// Assumes a 40 MHz system clock and a 1 us instruction cycle.
package ssp_pkg;

  // Bus geometry.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PSW = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IMASK = 5'h10;

  // Register indices returned by the address decoder.
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_PSW = 3'h1;
  localparam logic [2:0] SEL_DATA = 3'h2;
  localparam logic [2:0] SEL_ISTAT = 3'h3;
  localparam logic [2:0] SEL_IMASK = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // Field positions of the main control register.
  localparam int CTRL_RATE_LO = 0;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_PORT_SEL = 2;
  localparam int CTRL_PHASE = 3;
  localparam int CTRL_CLK_OUT = 4;
  localparam int CTRL_DOUT_EN = 5;

  // Field positions of the status word and the interrupt registers.
  localparam int PSW_BUSY = 0;
  localparam int IRQ_DONE = 0;

  // Timing: instruction cycle in clock cycles, and shift clock half periods.
  localparam int TC_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int TC_CYCLES = (TC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_FAST = 8'(TC_CYCLES);
  localparam logic [7:0] HALF_MID = 8'(2 * TC_CYCLES);
  localparam logic [7:0] HALF_SLOW = 8'(4 * TC_CYCLES);
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } ssp_fsm_t;

  typedef struct packed {
    ssp_fsm_t state;
    logic [1:0] rateSel;
    logic portSel;
    logic phaseAlt;
    logic clkOut;
    logic doutEn;
    logic [7:0] shiftReg;
    logic inBit;
    logic outBit;
    logic [3:0] bitCnt;
    logic [7:0] divCnt;
    logic sckOut;
    logic sckOe;
    logic sdoOe;
    logic sckPrev;
    logic irqStatus;
    logic irqMask;
    logic irq;
    logic awHave;
    logic [ADDR_W-1:0] awAddr;
    logic wHave;
    logic [7:0] wData;
    logic wStrb0;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
  } ssp_regs_t;

  localparam ssp_regs_t REGS_RESET = '{
    state: ST_IDLE,
    awReady: 1'b1,
    wReady: 1'b1,
    arReady: 1'b1,
    default: '0
  };

endpackage : ssp_pkg

// >>> ssp_sync2.sv
// Two flip-flop synchroniser for levels entering the system clock domain.
// Assumes the inputs are asynchronous pins; only the second stage is read.
`timescale 1ns/100ps
module ssp_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Levels.
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule : ssp_sync2

// >>> ssp_shift_port.sv
// Eight-bit synchronous serial shift port with an AXI4-Lite register slave.
// Assumes pins arrive asynchronously and the pad logic resolves enables.
`timescale 1ns/100ps
module ssp_shift_port (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // AXI4-Lite write address.
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [ssp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [ssp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins.
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutOe,
  input wire logic shiftClockIn,
  output logic shiftClockOut,
  output logic shiftClockOe,
  // Interrupt.
  output logic irq
);

  ssp_pkg::ssp_regs_t r;
  ssp_pkg::ssp_regs_t n;
  logic [1:0] pinSync;
  logic sdiSync;
  logic sckSync;

  // Both pins pass two flip-flops before any logic reads them.
  ssp_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async({shiftClockIn, serialDataIn}),
    .synced(pinSync)
  );

  assign sdiSync = pinSync[0];
  assign sckSync = pinSync[1];

  // Maps a byte address to a register index, or to none when unmapped.
  function automatic logic [2:0] regSel(input logic [ssp_pkg::ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = ssp_pkg::SEL_NONE;
    case (addr)
      ssp_pkg::OFS_CTRL: sel = ssp_pkg::SEL_CTRL;
      ssp_pkg::OFS_PSW: sel = ssp_pkg::SEL_PSW;
      ssp_pkg::OFS_DATA: sel = ssp_pkg::SEL_DATA;
      ssp_pkg::OFS_ISTAT: sel = ssp_pkg::SEL_ISTAT;
      ssp_pkg::OFS_IMASK: sel = ssp_pkg::SEL_IMASK;
      default: sel = ssp_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : regSel

  // Gives the shift clock half period in system clocks for a rate setting.
  function automatic logic [7:0] halfCycles(input logic [1:0] rate);
    logic [7:0] half;
    half = ssp_pkg::HALF_FAST;
    if (rate[1]) begin
      half = ssp_pkg::HALF_SLOW;
    end else if (rate[0]) begin
      half = ssp_pkg::HALF_MID;
    end
    return half;
  endfunction : halfCycles

  always_comb begin
    logic busy;
    logic riseEv;
    logic fallEv;
    logic doneEv;
    logic doWrite;
    logic [2:0] rsel;
    logic [2:0] wsel;
    busy = 1'b0;
    riseEv = 1'b0;
    fallEv = 1'b0;
    doneEv = 1'b0;
    doWrite = 1'b0;
    rsel = ssp_pkg::SEL_NONE;
    wsel = ssp_pkg::SEL_NONE;
    // Every field keeps its value unless a branch below changes it.
    n = r;
    n.sckPrev = sckSync;
    busy = (r.state == ssp_pkg::ST_SHIFT);

    // Read channel: one read at a time, answered one cycle after the address.
    if (s_axi_arvalid && r.arReady) begin
      rsel = regSel(s_axi_araddr);
      n.rValid = 1'b1;
      n.rResp = ssp_pkg::RESP_OKAY;
      n.rData = '0;
      case (rsel)
        ssp_pkg::SEL_CTRL: begin
          n.rData[ssp_pkg::CTRL_RATE_HI:ssp_pkg::CTRL_RATE_LO] = r.rateSel;
          n.rData[ssp_pkg::CTRL_PORT_SEL] = r.portSel;
          n.rData[ssp_pkg::CTRL_PHASE] = r.phaseAlt;
          n.rData[ssp_pkg::CTRL_CLK_OUT] = r.clkOut;
          n.rData[ssp_pkg::CTRL_DOUT_EN] = r.doutEn;
        end
        ssp_pkg::SEL_PSW: n.rData[ssp_pkg::PSW_BUSY] = busy;
        ssp_pkg::SEL_DATA: n.rData[7:0] = r.shiftReg;
        ssp_pkg::SEL_ISTAT: begin
          n.rData[ssp_pkg::IRQ_DONE] = r.irqStatus;
          n.irqStatus = 1'b0;
        end
        ssp_pkg::SEL_IMASK: n.rData[ssp_pkg::IRQ_DONE] = r.irqMask;
        default: n.rResp = ssp_pkg::RESP_SLVERR;
      endcase
    end else if (r.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
    end

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && r.awReady) begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wReady) begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata[7:0];
      n.wStrb0 = s_axi_wstrb[0];
    end
    if (r.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
    end
    if (r.awHave && r.wHave && !r.bValid) begin
      doWrite = 1'b1;
      wsel = regSel(r.awAddr);
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = (wsel == ssp_pkg::SEL_NONE) ? ssp_pkg::RESP_SLVERR : ssp_pkg::RESP_OKAY;
    end

    // Shift clock edges: own divider as master, synchronised pin as slave.
    if (busy && r.portSel) begin
      if (r.clkOut) begin
        if (r.divCnt >= halfCycles(r.rateSel) - 8'h01) begin
          n.divCnt = '0;
          n.sckOut = !r.sckOut;
          riseEv = !r.sckOut;
          fallEv = r.sckOut;
        end else begin
          n.divCnt = r.divCnt + 8'h01;
        end
      end else begin
        riseEv = sckSync && !r.sckPrev;
        fallEv = !sckSync && r.sckPrev;
      end
    end

    // Normal phase samples on the rising edge; alternate phase updates the output there.
    if (riseEv) begin
      if (r.phaseAlt) begin
        n.outBit = r.shiftReg[7];
      end else begin
        n.inBit = sdiSync;
      end
    end

    // The register shifts on every falling edge, most significant bit out first.
    if (fallEv) begin
      n.shiftReg = {r.shiftReg[6:0], r.phaseAlt ? sdiSync : r.inBit};
      n.bitCnt = r.bitCnt + 4'h1;
      if (r.bitCnt == ssp_pkg::LAST_BIT) begin
        n.state = ssp_pkg::ST_IDLE;
        n.bitCnt = '0;
        doneEv = 1'b1;
      end
    end

    // Register writes.
    if (doWrite && s_axi_wstrb_ok(r.wStrb0)) begin
      case (wsel)
        ssp_pkg::SEL_CTRL: begin
          n.rateSel = r.wData[ssp_pkg::CTRL_RATE_HI:ssp_pkg::CTRL_RATE_LO];
          n.portSel = r.wData[ssp_pkg::CTRL_PORT_SEL];
          n.phaseAlt = r.wData[ssp_pkg::CTRL_PHASE];
          n.clkOut = r.wData[ssp_pkg::CTRL_CLK_OUT];
          n.doutEn = r.wData[ssp_pkg::CTRL_DOUT_EN];
        end
        ssp_pkg::SEL_PSW: begin
          if (r.wData[ssp_pkg::PSW_BUSY]) begin
            if (!busy && r.portSel) begin
              n.state = ssp_pkg::ST_SHIFT;
              n.bitCnt = '0;
              n.divCnt = '0;
            end
          end else if (busy) begin
            n.state = ssp_pkg::ST_IDLE;
            n.bitCnt = '0;
            n.divCnt = '0;
          end
        end
        ssp_pkg::SEL_DATA: n.shiftReg = r.wData;
        ssp_pkg::SEL_ISTAT: n.irqStatus = n.irqStatus;
        ssp_pkg::SEL_IMASK: n.irqMask = r.wData[ssp_pkg::IRQ_DONE];
        default: n.state = n.state;
      endcase
    end

    // A completion sets the sticky flag even in the cycle of a clearing read.
    if (doneEv) begin
      n.irqStatus = 1'b1;
    end

    // Deselecting the port aborts a running shift.
    if (!n.portSel) begin
      n.state = ssp_pkg::ST_IDLE;
    end

    // Clock rests low outside a shift and is driven only as master.
    if (n.state != ssp_pkg::ST_SHIFT || !n.clkOut) begin
      n.sckOut = 1'b0;
      n.divCnt = '0;
    end
    if (!n.phaseAlt || n.state != ssp_pkg::ST_SHIFT) begin
      n.outBit = n.shiftReg[7];
    end
    // The alternate phase holds its last bit through the final falling edge.
    if (r.phaseAlt && doneEv) begin
      n.outBit = r.outBit;
    end
    // Pin enables and ready signals follow the next state.
    n.sckOe = n.portSel && n.clkOut;
    n.sdoOe = n.portSel && n.doutEn;
    n.irq = n.irqStatus && n.irqMask;
    n.awReady = !n.awHave;
    n.wReady = !n.wHave;
    n.arReady = !n.rValid;
  end

  // Byte lane 0 carries every register field.
  function automatic logic s_axi_wstrb_ok(input logic strb0);
    return strb0;
  endfunction : s_axi_wstrb_ok

  // All state moves at once, so every output comes straight from a flip-flop.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= ssp_pkg::REGS_RESET;
    end else begin
      r <= n;
    end
  end

  // Outputs are fields of the registered state.
  assign s_axi_awready = r.awReady;
  assign s_axi_wready = r.wReady;
  assign s_axi_bvalid = r.bValid;
  assign s_axi_bresp = r.bResp;
  assign s_axi_arready = r.arReady;
  assign s_axi_rvalid = r.rValid;
  assign s_axi_rdata = r.rData;
  assign s_axi_rresp = r.rResp;
  assign serialDataOut = r.outBit;
  assign serialDataOutOe = r.sdoOe;
  assign shiftClockOut = r.sckOut;
  assign shiftClockOe = r.sckOe;
  assign irq = r.irq;

endmodule : ssp_shift_port

// >>> ssp_shift_port_properties.sv
// Concurrent checks of the serial shift port, seen at its ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
module ssp_shift_port_properties (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ssp_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins and interrupt.
  input wire logic serialDataOut,
  input wire logic shiftClockOut,
  input wire logic shiftClockOe,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_high_min: assert property (
    $rose(shiftClockOut) |-> shiftClockOut[*8]) else $error("clock high too short");
  a_high_max: assert property (
    $rose(shiftClockOut) |-> ##[1:160] !shiftClockOut) else $error("clock high too long");
  a_master_drive: assert property (
    $rose(shiftClockOut) |-> shiftClockOe) else $error("clock toggles undriven");
  a_dout_edge: assert property (
    $changed(serialDataOut) |-> !shiftClockOut || $rose(shiftClockOut))
    else $error("data out moved mid high");
  a_irq_end: assert property (
    $rose(irq) |-> !shiftClockOut) else $error("interrupt mid transfer");
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_clock: cover property ($fell(shiftClockOut));
endmodule : ssp_shift_port_properties

bind ssp_shift_port ssp_shift_port_properties ssp_shift_port_properties_i (.clk_sys, .nrst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .serialDataOut, .shiftClockOut, .shiftClockOe, .irq);

// >>> ssp_far_end.sv
// Far-end shift device: answers a byte on the shared shift clock.
// Assumes the clock pin level is resolved by the bench.
`timescale 1ns/100ps
module ssp_far_end (
  // Link pins.
  input wire logic sck,
  input wire logic din,
  output logic dout,
  // Bench side.
  input wire logic load,
  input wire logic alt,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte
);
  logic [7:0] sh;
  int cnt;
  // It never drives the clock, it only follows it.
  always @(posedge load or negedge sck) begin
    if (load) begin
      sh = txByte;
      cnt = 0;
    end else begin
      sh = {sh[6:0], 1'b0};
      cnt++;
    end
    dout = (cnt < 8) ? sh[7] : ~dout;
  end
  // Normal phase samples on the rising edge, alternate phase on the falling edge.
  always @(posedge sck or negedge sck) begin
    if (sck ^ alt) rxByte <= {rxByte[6:0], din};
  end
endmodule : ssp_far_end

// >>> ssp_testbench.sv
// Self-checking bench of the serial shift port.
// Assumes the checker and the far-end model are compiled first.
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [7:0] ctl; int tcs; logic [7:0] tx; logic [7:0] rx;} ssp_row_t;
  ssp_row_t rows[5] = '{'{8'h34, 2, 8'hA5, 8'h3C}, '{8'h35, 4, 8'h81, 8'h7E},
    '{8'h36, 8, 8'h01, 8'hF0}, '{8'h37, 8, 8'hFF, 8'h00}, '{8'h3C, 2, 8'h5A, 8'hC3}};
  logic clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic serialDataOut, serialDataOutOe, shiftClockOut, shiftClockOe, irq;
  logic extSck, load, sckPin, soPin, siPin, altPh;
  logic [7:0] farTx, farRx;
  int bad_count, checks, n;
  assign sckPin = shiftClockOe ? shiftClockOut : extSck;
  assign soPin = serialDataOutOe ? serialDataOut : ~serialDataOut;
  ssp_shift_port ssp_shift_port_i (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialDataIn(siPin), .serialDataOut,
    .serialDataOutOe, .shiftClockIn(sckPin), .shiftClockOut, .shiftClockOe, .irq);
  ssp_far_end ssp_far_end_i (.sck(sckPin), .din(soPin), .dout(siPin), .load, .alt(altPh),
    .txByte(farTx), .rxByte(farRx));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: pin %b not %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    chk32(rdv, exp);
    chk32(32'(rsp), 32'(ssp_pkg::RESP_OKAY));
  endtask : rdc
  task automatic start(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] rx);
    wr(ssp_pkg::OFS_CTRL, 32'(ctl));
    farTx <= rx;
    altPh <= ctl[3];
    load <= 1'b1;
    wr(ssp_pkg::OFS_DATA, 32'(tx));
    load <= 1'b0;
    wr(ssp_pkg::OFS_PSW, 32'h0000_0001);
  endtask : start
  task automatic wait_idle();
    for (int i = 0; i < 2000; i++) begin
      rd(ssp_pkg::OFS_PSW);
      if (rdv[0] === 1'b0) break;
    end
  endtask : wait_idle
  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, extSck, load, farTx, altPh} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(ssp_pkg::OFS_CTRL, 32'h0000_0000);
    chk1(shiftClockOe, 1'b0);
    rd(5'h14);
    chk32({rdv[31:2], rsp}, 32'h0000_0002);
    wr(5'h14, 32'h0000_0001);
    chk32(32'(rsp), 32'h0000_0002);
    wr(ssp_pkg::OFS_IMASK, 32'h0000_0001);
    $display("reset and map test done");
    foreach (rows[i]) begin
      start(rows[i].ctl, rows[i].tx, rows[i].rx);
      while (shiftClockOut !== 1'b1) @(posedge clk_sys);
      n = 0;
      while (shiftClockOut === 1'b1) begin
        @(posedge clk_sys);
        n++;
      end
      chk32(32'(n), 32'(rows[i].tcs * ssp_pkg::TC_CYCLES / 2));
      wait_idle();
      chk1(rdv[0], 1'b0);
      chk1(irq, 1'b1);
      rdc(ssp_pkg::OFS_ISTAT, 32'h0000_0001);
      chk1(irq, 1'b0);
      rdc(ssp_pkg::OFS_DATA, 32'(rows[i].rx));
      chk32(32'(farRx), 32'(rows[i].tx));
      chk1(shiftClockOut, 1'b0);
      $display("row %0d test done", i);
    end
    wr(ssp_pkg::OFS_CTRL, 32'h0000_0030);
    wr(ssp_pkg::OFS_PSW, 32'h0000_0001);
    rdc(ssp_pkg::OFS_PSW, 32'h0000_0000);
    start(8'h36, 8'hC3, 8'h5A);
    while (shiftClockOut !== 1'b1) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    wr(ssp_pkg::OFS_PSW, 32'h0000_0000);
    chk1(shiftClockOut, 1'b0);
    rdc(ssp_pkg::OFS_ISTAT, 32'h0000_0000);
    wr(ssp_pkg::OFS_IMASK, 32'h0000_0000);
    start(8'h34, 8'h12, 8'h34);
    wait_idle();
    chk1(irq, 1'b0);
    rdc(ssp_pkg::OFS_ISTAT, 32'h0000_0001);
    $display("abort and mask test done");
    start(8'h24, 8'h96, 8'h69);
    repeat (50) @(posedge clk_sys);
    rdc(ssp_pkg::OFS_PSW, 32'h0000_0001);
    chk1(shiftClockOe, 1'b0);
    repeat (16) begin
      repeat (4) @(posedge clk_sys);
      extSck <= ~extSck;
    end
    wait_idle();
    rdc(ssp_pkg::OFS_DATA, 32'h0000_0069);
    chk32(32'(farRx), 32'h0000_0096);
    $display("slave test done");
    end_of_test();
  end
endmodule : testbench
